// ---- core/ntbcfg_defs.vh ----
// ntbcfg_defs.vh: offsets, field positions, reset values for the bridge header
// assumes inclusion by bare name from the core files
`ifndef NTBCFG_DEFS_VH
`define NTBCFG_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define NTBCFG_OFF_IDENT      12'h000
`define NTBCFG_OFF_COMMAND    12'h004

// ----------------------------------------
// command bit positions
// ----------------------------------------
`define NTBCFG_CMD_IO_EN      0
`define NTBCFG_CMD_MEM_EN     1
`define NTBCFG_CMD_MASTER_EN  2
`define NTBCFG_CMD_SPECIAL    3
`define NTBCFG_CMD_MWI        4
`define NTBCFG_CMD_PALETTE    5
`define NTBCFG_CMD_PERR_EN    6
`define NTBCFG_CMD_WAIT       7
`define NTBCFG_CMD_SERR_EN    8
`define NTBCFG_CMD_FB2B       9
`define NTBCFG_CMD_INT_DIS    10

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define NTBCFG_CMD_RESET      16'h0000
`define NTBCFG_CMD_WMASK_FWD  16'h0147
`define NTBCFG_CMD_WMASK_REV  16'h0567

// ----------------------------------------
// palette decode addresses, low ten bits
// ----------------------------------------
`define NTBCFG_PAL_MASK       10'h3C6
`define NTBCFG_PAL_READ_IDX   10'h3C8
`define NTBCFG_PAL_DATA       10'h3C9

`endif

// ---- core/ntbcfg_palette_decode.v ----
// ntbcfg_palette_decode.v: combinational palette write address match
// assumes the caller qualifies the match with an i/o write strobe
`timescale 1ns/100ps
`default_nettype none
`include "ntbcfg_defs.vh"

module ntbcfg_palette_decode (
    // address in
    input  wire [15:0] io_addr,
    // match out
    output wire        hit
);

    wire [9:0] low_addr;

    // upper bits ignored, isa aliases also hit
    assign low_addr = io_addr[9:0];
    assign hit      = (low_addr == `NTBCFG_PAL_MASK) ||
                      (low_addr == `NTBCFG_PAL_READ_IDX) ||
                      (low_addr == `NTBCFG_PAL_DATA);

endmodule // ntbcfg_palette_decode

`default_nettype wire

// ---- core/ntbcfg_header.v ----
// ntbcfg_header.v: identification words and command register of the bridge header
// assumes a one-cycle config strobe on mclk from the primary interface logic
`timescale 1ns/100ps
`default_nettype none
`include "ntbcfg_defs.vh"

module ntbcfg_header #(
    parameter [15:0] MAKER_CODE = 16'hA5A5, // arbitrary value
    parameter [15:0] PART_CODE  = 16'h5A5A  // arbitrary value
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // mode straps, pins
    input  wire        nt_mode_pin,
    input  wire        reverse_mode_pin,
    // configuration access
    input  wire        cfg_req,
    input  wire        cfg_wr,
    input  wire [11:0] cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    output reg         cfg_ack,
    output reg         cfg_unmapped,
    // primary side requests
    input  wire        pri_io_req,
    input  wire        pri_io_wr,
    input  wire [15:0] pri_io_addr,
    input  wire        pri_mem_req,
    output wire        pri_io_claim,
    output wire        pri_mem_claim,
    output wire        pri_palette_claim,
    // mastering
    input  wire        fwd_req,
    output wire        pri_master_grant,
    input  wire        sec_req,
    output wire        sec_claim,
    // error reporting
    input  wire        parity_err_event,
    output wire        master_parity_set,
    input  wire        fatal_err_event,
    output wire        err_msg_send,
    output wire        serr_assert,
    // legacy interrupts
    input  wire [3:0]  intx_req,
    output wire [3:0]  intx_assert,
    // command view
    output wire [15:0] command_out
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [1:0] nt_sync_reg;
    reg [1:0] rev_sync_reg;
    wire      nt_mode;
    wire      rev_mode;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nt_sync_reg  <= 2'h0;
            rev_sync_reg <= 2'h0;
        end else begin
            nt_sync_reg  <= {nt_sync_reg[0], nt_mode_pin};
            rev_sync_reg <= {rev_sync_reg[0], reverse_mode_pin};
        end
    end

    assign nt_mode  = nt_sync_reg[1];
    assign rev_mode = rev_sync_reg[1];

    // ----------------------------------------
    // command register
    // ----------------------------------------
    reg  [15:0] command_reg;
    reg  [15:0] command_next;
    wire [15:0] wmask;
    wire [15:0] be_mask;
    wire        hit_ident;
    wire        hit_command;
    wire        access;

    // only the non-transparent layout is served here
    assign access      = cfg_req && nt_mode;
    localparam [11:0] OFF_IDENT   = `NTBCFG_OFF_IDENT;
    localparam [11:0] OFF_COMMAND = `NTBCFG_OFF_COMMAND;

    // word decode; byte offset bits 1:0 are covered by the byte enables
    assign hit_ident   = (cfg_addr[11:2] == OFF_IDENT[11:2]);
    assign hit_command = (cfg_addr[11:2] == OFF_COMMAND[11:2]);

    // bits 3,4,7,9,11..15 never writable; 5 and 10 only in reverse mode
    assign wmask   = rev_mode ? `NTBCFG_CMD_WMASK_REV : `NTBCFG_CMD_WMASK_FWD;
    assign be_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};

    always @* begin
        command_next = command_reg;
        if (access && cfg_wr && hit_command) begin
            // plain rw fields; no sticky or clear-on-one bits live here
            command_next = (command_reg & ~(wmask & be_mask)) |
                           (cfg_wdata[15:0] & wmask & be_mask);
        end
        // leaving reverse mode drops the reverse-only bits
        if (!rev_mode) begin
            command_next[`NTBCFG_CMD_PALETTE] = 1'b0;
            command_next[`NTBCFG_CMD_INT_DIS] = 1'b0;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            command_reg <= `NTBCFG_CMD_RESET;
        end else begin
            command_reg <= command_next;
        end
    end

    assign command_out = command_reg;

    // ----------------------------------------
    // read path and acknowledge
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata    <= 32'h00000000;
            cfg_ack      <= 1'b0;
            cfg_unmapped <= 1'b0;
        end else begin
            cfg_ack      <= access;
            cfg_unmapped <= access && !hit_ident && !hit_command;
            if (access && !cfg_wr && hit_ident) begin
                cfg_rdata <= {PART_CODE, MAKER_CODE};
            end else if (access && !cfg_wr && hit_command) begin
                // status half belongs to another block, reads zero here
                cfg_rdata <= {16'h0000, command_reg};
            end else begin
                cfg_rdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // transaction gating
    // ----------------------------------------
    wire palette_hit;

    ntbcfg_palette_decode u_palette (
        .io_addr (pri_io_addr),
        .hit     (palette_hit)
    );

    assign pri_io_claim      = pri_io_req && command_reg[`NTBCFG_CMD_IO_EN];
    assign pri_mem_claim     = pri_mem_req && command_reg[`NTBCFG_CMD_MEM_EN];
    // snoop is a write-only claim; reads of the palette are not taken
    assign pri_palette_claim = pri_io_req && pri_io_wr && palette_hit &&
                               command_reg[`NTBCFG_CMD_PALETTE];
    assign pri_master_grant  = fwd_req && command_reg[`NTBCFG_CMD_MASTER_EN];
    assign sec_claim         = sec_req && command_reg[`NTBCFG_CMD_MASTER_EN];

    // ----------------------------------------
    // error reporting
    // ----------------------------------------
    assign master_parity_set = parity_err_event && command_reg[`NTBCFG_CMD_PERR_EN];
    assign err_msg_send      = fatal_err_event && command_reg[`NTBCFG_CMD_SERR_EN] &&
                               !rev_mode;
    assign serr_assert       = fatal_err_event && command_reg[`NTBCFG_CMD_SERR_EN] &&
                               rev_mode;

    // ----------------------------------------
    // legacy interrupt mask
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_intx
            assign intx_assert[gi] = intx_req[gi] && !command_reg[`NTBCFG_CMD_INT_DIS];
        end
    endgenerate

endmodule // ntbcfg_header

`default_nettype wire

// ---- verification/ntbcfg_header_assertions.sv ----
// checker on the bridge header ports
// assumes bind into ntbcfg_header, one clock domain
`timescale 1ns/100ps
`default_nettype none
module ntbcfg_chk (
    input wire logic        mclk, rst_n, cfg_req, cfg_wr, cfg_ack,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic        pri_io_req, pri_io_claim, pri_mem_req, pri_mem_claim,
    input wire logic        fwd_req, pri_master_grant, sec_req, sec_claim,
    input wire logic        parity_err_event, master_parity_set,
    input wire logic [3:0]  intx_req, intx_assert,
    input wire logic [15:0] command_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_io_gate: assert property (pri_io_claim == (pri_io_req & command_out[0]))
        else $error("io claim wrong");
    a_mem_gate: assert property (pri_mem_claim == (pri_mem_req & command_out[1]))
        else $error("mem claim wrong");
    a_master_gate: assert property (pri_master_grant == (fwd_req & command_out[2]))
        else $error("grant wrong");
    a_sec_gate: assert property (sec_claim == (sec_req & command_out[2]))
        else $error("sec claim wrong");
    a_fixed_zero: assert property ((command_out & 16'hFA98) == 16'h0000)
        else $error("fixed bit set");
    a_parity_gate: assert property (master_parity_set == (parity_err_event & command_out[6]))
        else $error("parity set wrong");
    a_intx_mask: assert property (intx_assert == (intx_req & {4{!command_out[10]}}))
        else $error("intx mask wrong");
    a_ident_read: assert property (cfg_ack && $past(!cfg_wr && cfg_addr == 12'h000)
        |-> cfg_rdata == 32'h5A5AA5A5) else $error("ident wrong");
    a_ack_cause: assert property (cfg_ack |-> $past(cfg_req))
        else $error("stray ack");
    c_ident: cover property (cfg_ack && $past(!cfg_wr && cfg_addr == 12'h000));
    c_cmd_wr: cover property (cfg_ack && $past(cfg_wr && cfg_addr == 12'h004));
    c_intx_off: cover property (command_out[10] && intx_req != 4'h0);
endmodule // ntbcfg_chk
bind ntbcfg_header ntbcfg_chk i_ntbcfg_chk (.*);
`default_nettype wire

// ---- verification/ntbcfg_host.sv ----
// host model issuing configuration accesses
// assumes the bench calls xfer from falling edges
`timescale 1ns/100ps
`default_nettype none
module ntbcfg_host (
    input  wire logic        mclk, cfg_ack, cfg_unmapped,
    input  wire logic [31:0] cfg_rdata,
    output var  logic        cfg_req, cfg_wr,
    output var  logic [11:0] cfg_addr,
    output var  logic [3:0]  cfg_be,
    output var  logic [31:0] cfg_wdata
);
    initial {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = 50'h0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] b,
        input logic [31:0] d, output logic [31:0] rd, output logic k, output logic u);
        @(negedge mclk);
        {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, b, d};
        @(negedge mclk);
        {rd, k, u} = {cfg_rdata, cfg_ack, cfg_unmapped};
        // released lines show no stale value
        {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b0, ~w, ~a, ~b, ~d};
    endtask
endmodule // ntbcfg_host
`default_nettype wire

// ---- verification/ntbcfg_header_tb.sv ----
// self-checking bench for the bridge header
// assumes host model and checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ntbcfg_header_tb;
    logic mclk = 1'b0, rst_n = 1'b0, nt_mode_pin = 1'b1, reverse_mode_pin = 1'b0;
    logic pri_io_req = 1'b0, pri_io_wr = 1'b0, pri_mem_req = 1'b0, fwd_req = 1'b0;
    logic sec_req = 1'b0, parity_err_event = 1'b0, fatal_err_event = 1'b0;
    logic [15:0] pri_io_addr = 16'h0000, command_out;
    logic [3:0]  intx_req = 4'h0, cfg_be, intx_assert;
    logic cfg_req, cfg_wr, cfg_ack, cfg_unmapped, pri_io_claim, pri_mem_claim, k, u;
    logic pri_palette_claim, pri_master_grant, sec_claim, master_parity_set;
    logic err_msg_send, serr_assert;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, rd;
    int error_cnt = 0, num_checks = 0;
    wire logic [6:0] gates = {pri_io_claim, pri_mem_claim, pri_master_grant, sec_claim,
        master_parity_set, err_msg_send, serr_assert};
    ntbcfg_header i_ntbcfg_header (.*);
    ntbcfg_host i_ntbcfg_host (.*);
    initial forever #12.5 mclk = ~mclk;
    task automatic x(input logic w, input logic [11:0] a, input logic [3:0] b,
        input logic [15:0] d);
        i_ntbcfg_host.xfer(w, a, b, {16'hFFFF, d}, rd, k, u);
    endtask
    task automatic t_ident;
        x(1'b1, 12'h000, 4'hF, 16'h0000);
        x(1'b0, 12'h000, 4'hF, 16'h0000);
        `CHK({k, rd}, 33'h15A5AA5A5)
        x(1'b0, 12'h008, 4'hF, 16'h0000);
        `CHK({k, u, rd}, 34'h300000000)
        $display("ident test done");
    endtask
    task automatic t_fwd;
        x(1'b1, 12'h004, 4'h3, 16'hFFFF);
        `CHK(command_out, 16'h0147)
        {pri_io_req, pri_mem_req, fwd_req, sec_req, parity_err_event, fatal_err_event} = 6'h3F;
        #1 `CHK(gates, 7'h7E)
        x(1'b1, 12'h004, 4'h3, 16'h0000);
        `CHK(gates, 7'h00)
        x(1'b1, 12'h004, 4'h1, 16'hFFFF);
        x(1'b0, 12'h004, 4'hF, 16'h0000);
        `CHK(rd, 32'h00000047)
        $display("forward test done");
    endtask
    task automatic t_rev;
        {reverse_mode_pin, intx_req, pri_io_wr, pri_io_addr} = {5'h1F, 1'b1, 16'hF3C6};
        repeat (2) @(negedge mclk);
        x(1'b1, 12'h004, 4'h3, 16'hFFFF);
        `CHK(command_out, 16'h0567)
        #1 `CHK({intx_assert, pri_palette_claim, gates[1:0]}, 7'h05)
        pri_io_addr = 16'h03C8;
        #1 `CHK(pri_palette_claim, 1'b1)
        pri_io_addr = 16'h83C9;
        #1 `CHK(pri_palette_claim, 1'b1)
        pri_io_addr = 16'h03C7;
        #1 `CHK(pri_palette_claim, 1'b0)
        @(negedge mclk);
        {pri_io_wr, pri_io_addr} = {1'b0, 16'h03C9};
        #1 `CHK(pri_palette_claim, 1'b0)
        @(negedge mclk);
        reverse_mode_pin = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK(command_out, 16'h0147)
        `CHK(intx_assert, 4'hF)
        $display("reverse test done");
    endtask
    task automatic t_mode;
        nt_mode_pin = 1'b0;
        repeat (2) @(negedge mclk);
        x(1'b1, 12'h004, 4'h3, 16'h0000);
        `CHK({k, command_out}, 17'h00147)
        @(negedge mclk);
        {nt_mode_pin, rst_n} = 2'b10;
        #1 `CHK(command_out, 16'h0000)
        @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        $display("mode test done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        t_ident;
        t_fwd;
        t_rev;
        t_mode;
        wrap_up;
    end
endmodule // ntbcfg_header_tb
`default_nettype wire
